// [dv/clar_cryostat_model.sv]
`timescale 1ns/100ps
module clar_cryostat_model (
    input  wire logic                     core_clk,
    input  wire logic                     rstn,
    input  wire logic                     valveOpen,
    input  wire logic                     autoRun,
    input  wire logic                     setStrobe,
    input  wire clar_pkg::clar_level_type setLevel,
    output logic                          sampleValid,
    output clar_pkg::clar_level_type      sampleLevel
);
    import clar_pkg::*;
    logic [2:0]     stepCnt_r;
    clar_level_type level_r;
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            stepCnt_r   <= 3'h0;
            sampleValid <= 1'b0;
            level_r     <= 16'h0000;
        end else begin
            stepCnt_r   <= stepCnt_r + 3'h1;
            sampleValid <= setStrobe || (autoRun && stepCnt_r == 3'h7);
            if (setStrobe) begin
                level_r <= setLevel;
            end else if (autoRun && stepCnt_r == 3'h7) begin
                if (valveOpen) begin
                    level_r <= level_r + 16'h0010;
                end else if (level_r >= 16'h0010) begin
                    level_r <= level_r - 16'h0010;
                end
            end
        end
    end
    assign sampleLevel = sampleValid ? level_r : ~level_r;
endmodule : clar_cryostat_model

// [dv/clar_level_alarm_properties.sv]
`timescale 1ns/100ps
module clar_level_alarm_properties (
    input wire logic                     core_clk,
    input wire logic                     rstn,
    input wire clar_pkg::clar_addr_type  regAddr,
    input wire clar_pkg::clar_word_type  regWdata,
    input wire logic                     regWrite,
    input wire logic                     sample0Valid,
    input wire clar_pkg::clar_level_type sample0Level,
    input wire logic                     keyPress,
    input wire logic                     refill0Out,
    input wire logic                     refill1Out,
    input wire logic                     fill0Ind,
    input wire logic                     fill1Ind,
    input wire logic                     alarm0Ind,
    input wire logic                     beepOut
);
    import clar_pkg::*;
    clar_level_type low0_r, high0_r, alarm0_r, alarm1_r, tmo0_r;
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            {low0_r, high0_r, alarm0_r, alarm1_r, tmo0_r} <= '0;
        end else if (regWrite) begin
            case (regAddr)
                8'h04: low0_r   <= regWdata[15:0];
                8'h08: high0_r  <= regWdata[15:0];
                8'h0C: alarm0_r <= regWdata[15:0];
                8'h10: tmo0_r   <= regWdata[15:0];
                8'h1C: alarm1_r <= regWdata[15:0];
                default: ;
            endcase
        end
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);
    sequence lowSample;
        sample0Valid && sample0Level < low0_r && low0_r != 16'h0000 && !regWrite;
    endsequence
    sequence keyRise;
        !keyPress ##1 keyPress;
    endsequence
    a_fill_start: assert property (lowSample ##0 (!refill0Out && !$past(refill0Out))
        |=> refill0Out) else $error("no refill start");
    a_fill_hold: assert property (refill0Out && !(sample0Valid && sample0Level > high0_r)
        && !regWrite && tmo0_r == 16'h0000 && low0_r != 16'h0000 |=> refill0Out)
        else $error("refill dropped early");
    a_fill_stop: assert property (refill0Out && sample0Valid && sample0Level > high0_r
        |=> !refill0Out) else $error("refill held high");
    a_zero_low: assert property (low0_r == 16'h0000 && !refill0Out && !regWrite
        && !$past(regWrite) |=> !refill0Out) else $error("refill with zero low limit");
    a_fill_ind: assert property (fill0Ind == refill0Out && fill1Ind == refill1Out)
        else $error("fill ind mismatch");
    a_chan_indep: assert property (!sample0Valid && !regWrite && !$past(regWrite)
        && tmo0_r == 16'h0000 |=> $stable(refill0Out)) else $error("refill0 moved");
    a_vis_set: assert property (sample0Valid && sample0Level < alarm0_r && !regWrite
        |=> alarm0Ind) else $error("visual alarm not set");
    a_vis_clear: assert property (alarm0Ind && sample0Valid && sample0Level > alarm0_r
        |=> !alarm0Ind) else $error("visual alarm not cleared");
    a_zero_alarm: assert property (alarm0_r == 16'h0000 && alarm1_r == 16'h0000
        && !beepOut |=> !beepOut) else $error("beep with zero setpoints");
    a_key_silence: assert property (keyRise |-> ##[1:4] !beepOut)
        else $error("key did not silence beep");
endmodule : clar_level_alarm_properties
bind clar_level_alarm clar_level_alarm_properties chk_u (.*);

// [dv/tb.sv]
`timescale 1ns/100ps
module tb;
    import clar_pkg::*;
    logic           core_clk, rstn, regWrite, regRead, sample1Valid, keyPress, chanSelPin;
    logic           autoRun, setStrobe, sample0Valid, refill0Out, refill1Out;
    logic           fill0Ind, fill1Ind, alarm0Ind, alarm1Ind, beepOut, irqOut;
    logic [15:0]    analogOut;
    clar_addr_type  regAddr;
    clar_word_type  regWdata, regRdata, v;
    clar_level_type sample1Level, setLevel, sample0Level;
    int             fails, comparisons;
    clar_level_alarm #(.TICK_CYC(4)) dut_u (.*);
    clar_cryostat_model model_u (.*, .valveOpen(refill0Out), .sampleValid(sample0Valid),
        .sampleLevel(sample0Level));
    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end
    task automatic summarize();
        $display("comparisons=%0d fails=%0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : summarize
    task automatic chk(input string nm, input clar_word_type got, input clar_word_type exp);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask : cyc
    task automatic wr(input clar_addr_type a, input clar_word_type d);
        @(posedge core_clk);
        regWrite <= 1'b1;
        regAddr  <= a;
        regWdata <= d;
        @(posedge core_clk);
        regWrite <= 1'b0;
    endtask : wr
    task automatic rd(input clar_addr_type a, output clar_word_type d);
        @(posedge core_clk);
        regRead <= 1'b1;
        regAddr <= a;
        @(posedge core_clk);
        regRead <= 1'b0;
        #1 d = regRdata;
    endtask : rd
    task automatic smp0(input clar_level_type l);
        @(posedge core_clk);
        setStrobe <= 1'b1;
        setLevel  <= l;
        @(posedge core_clk);
        setStrobe <= 1'b0;
        cyc(3);
    endtask : smp0
    task automatic smp1(input clar_level_type l);
        @(posedge core_clk);
        sample1Valid <= 1'b1;
        sample1Level <= l;
        @(posedge core_clk);
        sample1Valid <= 1'b0;
        sample1Level <= ~l;
        cyc(2);
    endtask : smp1
    task automatic key();
        @(posedge core_clk);
        keyPress <= 1'b1;
        repeat (6) @(posedge core_clk);
        keyPress <= 1'b0;
        cyc(4);
    endtask : key
    initial begin
        repeat (20000) @(posedge core_clk);
        fails++;
        summarize();
    end
    initial begin : main
        clar_addr_type  adr [6];
        clar_word_type  rst [6];
        clar_level_type lv  [4];
        logic           ex  [4];
        adr = '{8'h00, 8'h04, 8'h24, 8'h28, 8'h2C, 8'h3C};
        rst = '{0: 32'h0000_0001, default: 32'h0000_0000};
        lv  = '{16'h0096, 16'h00C8, 16'h00C9, 16'h0096};
        ex  = '{1'b1, 1'b1, 1'b0, 1'b0};
        {rstn, regWrite, regRead, sample1Valid, keyPress, autoRun, setStrobe} = '0;
        {regAddr, regWdata, sample1Level, setLevel} = '0;
        chanSelPin = 1'b1;
        repeat (20) @(posedge core_clk);
        rstn <= 1'b1;
        wr(8'h3C, 32'h0000_FFFF);
        for (int i = 0; i < 6; i++) begin
            rd(adr[i], v);
            chk("reset value", v, rst[i]);
        end
        smp0(16'h0000);
        chk("refill0 zero low", refill0Out, 0);
        chk("beep zero alarm", beepOut, 0);
        $display("test reset done");
        wr(8'h04, 32'h0000_0064);
        wr(8'h08, 32'h0000_00C8);
        smp0(16'h0032);
        chk("refill0 low", refill0Out, 1);
        chk("fill0 ind", fill0Ind, 1);
        for (int i = 0; i < 4; i++) begin
            smp0(lv[i]);
            chk("refill0 hyst", refill0Out, ex[i]);
        end
        $display("test hysteresis done");
        wr(8'h28, 32'h0000_00FF);
        wr(8'h10, 32'h0000_0003);
        smp0(16'h0032);
        chk("refill0 tmo start", refill0Out, 1);
        cyc(30);
        chk("refill0 tmo end", refill0Out, 0);
        rd(8'h28, v);
        chk("irq timeout", v & 32'h0000_0010, 32'h0000_0010);
        chk("irq masked", irqOut, 0);
        wr(8'h2C, 32'h0000_0010);
        cyc(2);
        chk("irq unmasked", irqOut, 1);
        wr(8'h28, 32'h0000_0010);
        cyc(2);
        chk("irq cleared", irqOut, 0);
        wr(8'h10, 32'h0000_0000);
        $display("test timeout done");
        wr(8'h14, 32'h0000_0064);
        wr(8'h18, 32'h0000_00C8);
        smp1(16'h0032);
        chk("refill1 low", refill1Out, 1);
        chk("refill0 apart", refill0Out, 0);
        smp1(16'h00FA);
        chk("refill1 high", refill1Out, 0);
        wr(8'h1C, 32'h0000_0050);
        smp1(16'h0046);
        chk("beep ch1", beepOut, 1);
        chk("vis ch1", alarm1Ind, 1);
        $display("test channel1 done");
        @(posedge core_clk);
        rstn <= 1'b0;
        cyc(3);
        rstn <= 1'b1;
        wr(8'h0C, 32'h0000_0050);
        smp0(16'h0046);
        chk("beep ch0", beepOut, 1);
        key();
        chk("beep silenced", beepOut, 0);
        chk("vis kept", alarm0Ind, 1);
        smp0(16'h0046);
        chk("beep no rearm", beepOut, 0);
        smp0(16'h005A);
        chk("vis cleared", alarm0Ind, 0);
        smp0(16'h0046);
        chk("beep rearmed", beepOut, 1);
        $display("test alarm done");
        wr(8'h04, 32'h0000_0064);
        wr(8'h08, 32'h0000_00C8);
        smp0(16'h0096);
        wr(8'h00, 32'h0000_0005);
        cyc(2);
        chk("manual start", refill0Out, 1);
        wr(8'h00, 32'h0000_0021);
        cyc(2);
        chk("menu stop", refill0Out, 0);
        chk("menu vis", alarm0Ind, 0);
        wr(8'h00, 32'h0000_0005);
        smp0(16'h00C9);
        chk("manual high", refill0Out, 0);
        $display("test manual done");
        wr(8'h00, 32'h0000_0003);
        smp0(16'h0000);
        smp1(16'hFFFF);
        @(posedge core_clk);
        chanSelPin <= 1'b0;
        cyc(6);
        chk("analog sel low", analogOut, 32'h0000_3333);
        @(posedge core_clk);
        chanSelPin <= 1'b1;
        cyc(6);
        chk("analog sel high", analogOut, 32'h0000_FFFF);
        wr(8'h00, 32'h0000_0000);
        cyc(3);
        chk("analog single", analogOut, 32'h0000_0000);
        $display("test analog done");
        wr(8'h00, 32'h0000_0001);
        wr(8'h28, 32'h0000_00FF);
        @(posedge core_clk);
        autoRun <= 1'b1;
        cyc(800);
        autoRun <= 1'b0;
        rd(8'h28, v);
        chk("auto refill cycle", v & 32'h0000_0005, 32'h0000_0005);
        $display("test auto refill done");
        summarize();
    end
endmodule : tb

// [logic/clar_cfg.svh]
`ifndef CLAR_CFG_SVH
`define CLAR_CFG_SVH
// register byte offsets
`define CLAR_OFF_CTRL      8'h00
`define CLAR_OFF_LOW0      8'h04
`define CLAR_OFF_HIGH0     8'h08
`define CLAR_OFF_ALARM0    8'h0C
`define CLAR_OFF_TMO0      8'h10
`define CLAR_OFF_LOW1      8'h14
`define CLAR_OFF_HIGH1     8'h18
`define CLAR_OFF_ALARM1    8'h1C
`define CLAR_OFF_TMO1      8'h20
`define CLAR_OFF_STATUS    8'h24
`define CLAR_OFF_IRQSTAT   8'h28
`define CLAR_OFF_IRQMASK   8'h2C
`define CLAR_OFF_LEVEL0    8'h30
`define CLAR_OFF_LEVEL1    8'h34
`define CLAR_OFF_AOUT      8'h38
// control fields
`define CLAR_CTRL_DUAL     0
`define CLAR_CTRL_AOMODE   1
`define CLAR_CTRL_START0   2
`define CLAR_CTRL_START1   3
`define CLAR_CTRL_STOP     4
`define CLAR_CTRL_MENU     5
// status fields
`define CLAR_ST_FILL0      0
`define CLAR_ST_FILL1      1
`define CLAR_ST_VIS0       2
`define CLAR_ST_VIS1       3
`define CLAR_ST_BEEP       4
`define CLAR_ST_SILENT     5
// irq bits: fill start, fill end, timeout, alarm per channel
`define CLAR_IRQ_WIDTH     8
// reset values
`define CLAR_RST_CTRL      32'h0000_0001
`define CLAR_RST_WORD      32'h0000_0000
// timeout tick
`define CLAR_TICK_NS       1000000
`define CLAR_CLK_NS        4
`define CLAR_TICK_CYC      (`CLAR_TICK_NS / `CLAR_CLK_NS)
`endif

// [logic/clar_level_alarm.sv]
// Summary of operation
// - level below low limit starts refill output
// - refill holds until level above high limit
// - refill aborts after configurable transfer timeout
// - two channels refill independently, except shared stop/menu
// - zero low limit disables refill output
// - either channel below alarm setpoint sounds alarm
// - any key press silences sounding alarm
// - rearm needs normal reading then low reading
// - zero alarm setpoint disables audible alarm
// - select low or single mode picks sensor 1, else 2
// - analog output linear in selected level
// - visual alarm held until normal reading/menu
// - fill indicator shows while refill active
// - manual fill ends at high, timeout, menu
`timescale 1ns/100ps
`include "clar_cfg.svh"
module clar_level_alarm #(
    parameter int TICK_CYC = `CLAR_TICK_CYC
) (
    input  wire logic                     core_clk,
    input  wire logic                     rstn,
    input  wire clar_pkg::clar_addr_type  regAddr,
    input  wire clar_pkg::clar_word_type  regWdata,
    input  wire logic                     regWrite,
    input  wire logic                     regRead,
    output clar_pkg::clar_word_type       regRdata,
    input  wire logic                     sample0Valid,
    input  wire clar_pkg::clar_level_type sample0Level,
    input  wire logic                     sample1Valid,
    input  wire clar_pkg::clar_level_type sample1Level,
    input  wire logic                     keyPress,
    input  wire logic                     chanSelPin,
    output logic                          refill0Out,
    output logic                          refill1Out,
    output logic                          fill0Ind,
    output logic                          fill1Ind,
    output logic                          alarm0Ind,
    output logic                          alarm1Ind,
    output logic                          beepOut,
    output logic [15:0]                   analogOut,
    output logic                          irqOut
);
    import clar_pkg::*;

    clar_word_type   ctrl_r;

    clar_level_type  low_r   [2];

    clar_level_type  high_r  [2];

    clar_level_type  alarm_r [2];

    logic [15:0]     tmo_r   [2];

    clar_level_type  level_r [2];

    logic [`CLAR_IRQ_WIDTH-1:0] irqStat_r;

    logic [`CLAR_IRQ_WIDTH-1:0] irqMask_r;

    logic [`CLAR_IRQ_WIDTH-1:0] irqEvt;

    logic            keySync1_r;

    logic            keySync2_r;

    logic            keyPrev_r;

    logic            keyEdge;

    logic            selSync1_r;

    logic            selSync2_r;

    logic            beep_r;

    logic            silent_r;

    logic            armed_r;

    logic [1:0]      vis_r;

    logic [1:0]      vld;

    logic [1:0]      below;

    logic [1:0]      above;

    logic [1:0]      fillOn;

    logic [1:0]      fillStart;

    logic [1:0]      fillEnd;

    logic [1:0]      timedOut;

    logic [1:0]      startPulse;

    logic            stopPulse;

    logic            menuPulse;

    logic            dual;

    logic            useSecond;

    logic [15:0]     aoutRaw;

    clar_level_type  sLevel  [2];

    logic [31:0]     aoProd;

    function automatic logic hit(input clar_addr_type a, input logic [7:0] off);
        hit = (a == off);
    endfunction : hit

    assign dual       = ctrl_r[`CLAR_CTRL_DUAL];
    assign vld        = {sample1Valid & dual, sample0Valid};
    assign sLevel[0]  = sample0Level;
    assign sLevel[1]  = sample1Level;
    assign startPulse = {2{regWrite && hit(regAddr, `CLAR_OFF_CTRL)}}
                        & {regWdata[`CLAR_CTRL_START1], regWdata[`CLAR_CTRL_START0]};
    assign menuPulse  = regWrite && hit(regAddr, `CLAR_OFF_CTRL) && regWdata[`CLAR_CTRL_MENU];
    assign stopPulse  = (regWrite && hit(regAddr, `CLAR_OFF_CTRL) && regWdata[`CLAR_CTRL_STOP])
                        || menuPulse;

    // pin synchronisers
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            keySync1_r <= 1'b0;
            keySync2_r <= 1'b0;
            keyPrev_r  <= 1'b0;
            selSync1_r <= 1'b1;
            selSync2_r <= 1'b1;
        end else begin
            keySync1_r <= keyPress;
            keySync2_r <= keySync1_r;
            keyPrev_r  <= keySync2_r;
            selSync1_r <= chanSelPin;
            selSync2_r <= selSync1_r;
        end
    end
    assign keyEdge = keySync2_r && !keyPrev_r;

    // one refill controller per channel
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : gChan
            assign below[gi] = vld[gi] && (alarm_r[gi] != 16'h0000)
                               && (sLevel[gi] < alarm_r[gi]);
            assign above[gi] = vld[gi] && !(sLevel[gi] < alarm_r[gi]);
            clar_refill_chan #(
                .TICK_CYC     (TICK_CYC)
            ) uChan (
                .core_clk     (core_clk),
                .rstn         (rstn),
                .sampleValid  (vld[gi]),
                .levelIn      (sLevel[gi]),
                .lowLimit     (low_r[gi]),
                .highLimit    (high_r[gi]),
                .timeoutTicks (tmo_r[gi]),
                .manualStart  (startPulse[gi] && (gi == 0 || dual)),
                .manualStop   (stopPulse || (gi == 1 && !dual)),
                .fillOn       (fillOn[gi]),
                .fillStart    (fillStart[gi]),
                .fillEnd      (fillEnd[gi]),
                .timedOut     (timedOut[gi])
            );
            always_ff @(posedge core_clk or negedge rstn) begin
                if (!rstn) begin
                    level_r[gi] <= 16'h0000;
                end else if (vld[gi]) begin
                    level_r[gi] <= sLevel[gi];
                end
            end
            always_ff @(posedge core_clk or negedge rstn) begin
                if (!rstn) begin
                    vis_r[gi] <= 1'b0;
                end else if (below[gi]) begin
                    vis_r[gi] <= 1'b1;
                end else if (above[gi] || menuPulse || alarm_r[gi] == 16'h0000) begin
                    vis_r[gi] <= 1'b0;
                end
            end
        end
    endgenerate

    assign refill0Out = fillOn[0];
    assign refill1Out = fillOn[1];
    assign fill0Ind   = fillOn[0];
    assign fill1Ind   = fillOn[1];
    assign alarm0Ind  = vis_r[0];
    assign alarm1Ind  = vis_r[1];
    assign beepOut    = beep_r;

    // audible alarm with silence and rearm
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            beep_r   <= 1'b0;
            silent_r <= 1'b0;
            armed_r  <= 1'b1;
        end else begin
            if (alarm_r[0] == 16'h0000 && alarm_r[1] == 16'h0000) begin
                beep_r   <= 1'b0;
                silent_r <= 1'b0;
                armed_r  <= 1'b1;
            end else if (beep_r && keyEdge) begin
                beep_r   <= 1'b0;
                silent_r <= 1'b1;
                armed_r  <= 1'b0;
            end else if (|below) begin
                if (armed_r) begin
                    beep_r <= 1'b1;
                end
            end else if (|above) begin
                armed_r  <= 1'b1;
                silent_r <= 1'b0;
            end
        end
    end

    // analog output select and scale
    assign useSecond = dual && selSync2_r;
    assign aoutRaw   = useSecond ? level_r[1] : level_r[0];
    assign aoProd    = 32'(aoutRaw) * 32'h0000_CCCD;
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            analogOut <= 16'h0000;
        end else if (ctrl_r[`CLAR_CTRL_AOMODE]) begin
            analogOut <= 16'h3333 + aoProd[31:16];
        end else begin
            analogOut <= aoutRaw;
        end
    end

    // sticky interrupt status
    assign irqEvt = {below[1], below[0], timedOut, fillEnd, fillStart};
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            irqStat_r <= 8'h00;
        end else if (regWrite && hit(regAddr, `CLAR_OFF_IRQSTAT)) begin
            irqStat_r <= (irqStat_r & ~regWdata[7:0]) | irqEvt;
        end else begin
            irqStat_r <= irqStat_r | irqEvt;
        end
    end
    assign irqOut = |(irqStat_r & irqMask_r);

    // register writes
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            ctrl_r     <= `CLAR_RST_CTRL;
            irqMask_r  <= 8'h00;
            low_r[0]   <= 16'h0000;
            high_r[0]  <= 16'h0000;
            alarm_r[0] <= 16'h0000;
            tmo_r[0]   <= 16'h0000;

            low_r[1]   <= 16'h0000;
            high_r[1]  <= 16'h0000;
            alarm_r[1] <= 16'h0000;
            tmo_r[1]   <= 16'h0000;
        end else if (regWrite) begin
            if (hit(regAddr, `CLAR_OFF_CTRL)) begin
                ctrl_r <= {30'h0000_0000, regWdata[1:0]};
            end else if (hit(regAddr, `CLAR_OFF_IRQMASK)) begin
                irqMask_r <= regWdata[7:0];
            end else if (hit(regAddr, `CLAR_OFF_LOW0)) begin
                low_r[0] <= regWdata[15:0];
            end else if (hit(regAddr, `CLAR_OFF_HIGH0)) begin
                high_r[0] <= regWdata[15:0];
            end else if (hit(regAddr, `CLAR_OFF_ALARM0)) begin
                alarm_r[0] <= regWdata[15:0];
            end else if (hit(regAddr, `CLAR_OFF_TMO0)) begin
                tmo_r[0] <= regWdata[15:0];
            end else if (hit(regAddr, `CLAR_OFF_LOW1)) begin
                low_r[1] <= regWdata[15:0];
            end else if (hit(regAddr, `CLAR_OFF_HIGH1)) begin
                high_r[1] <= regWdata[15:0];
            end else if (hit(regAddr, `CLAR_OFF_ALARM1)) begin
                alarm_r[1] <= regWdata[15:0];
            end else if (hit(regAddr, `CLAR_OFF_TMO1)) begin
                tmo_r[1] <= regWdata[15:0];
            end
        end
    end

    // register reads, data one cycle later
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            regRdata <= `CLAR_RST_WORD;
        end else if (!regRead) begin
            regRdata <= `CLAR_RST_WORD;

        end else if (hit(regAddr, `CLAR_OFF_CTRL)) begin
            regRdata <= ctrl_r;

        end else if (hit(regAddr, `CLAR_OFF_LOW0)) begin
            regRdata <= {16'h0000, low_r[0]};

        end else if (hit(regAddr, `CLAR_OFF_HIGH0)) begin
            regRdata <= {16'h0000, high_r[0]};

        end else if (hit(regAddr, `CLAR_OFF_ALARM0)) begin
            regRdata <= {16'h0000, alarm_r[0]};

        end else if (hit(regAddr, `CLAR_OFF_TMO0)) begin
            regRdata <= {16'h0000, tmo_r[0]};

        end else if (hit(regAddr, `CLAR_OFF_LOW1)) begin
            regRdata <= {16'h0000, low_r[1]};

        end else if (hit(regAddr, `CLAR_OFF_HIGH1)) begin
            regRdata <= {16'h0000, high_r[1]};

        end else if (hit(regAddr, `CLAR_OFF_ALARM1)) begin
            regRdata <= {16'h0000, alarm_r[1]};

        end else if (hit(regAddr, `CLAR_OFF_TMO1)) begin
            regRdata <= {16'h0000, tmo_r[1]};

        end else if (hit(regAddr, `CLAR_OFF_STATUS)) begin
            regRdata <= {26'h000_0000, silent_r, beep_r, vis_r, fillOn};

        end else if (hit(regAddr, `CLAR_OFF_IRQSTAT)) begin
            regRdata <= {24'h00_0000, irqStat_r};

        end else if (hit(regAddr, `CLAR_OFF_IRQMASK)) begin
            regRdata <= {24'h00_0000, irqMask_r};

        end else if (hit(regAddr, `CLAR_OFF_LEVEL0)) begin
            regRdata <= {16'h0000, level_r[0]};

        end else if (hit(regAddr, `CLAR_OFF_LEVEL1)) begin
            regRdata <= {16'h0000, level_r[1]};

        end else if (hit(regAddr, `CLAR_OFF_AOUT)) begin
            regRdata <= {16'h0000, analogOut};
        end else begin
            regRdata <= `CLAR_RST_WORD;
        end
    end
endmodule : clar_level_alarm

// [logic/clar_pkg.sv]
package clar_pkg;
    typedef logic [15:0] clar_level_type;
    typedef logic [31:0] clar_word_type;
    typedef logic [7:0]  clar_addr_type;
    typedef enum logic [1:0] {
        CLAR_IDLE = 2'b00,
        CLAR_FILL = 2'b01,
        CLAR_DONE = 2'b11
    } clar_fill_type;
endpackage : clar_pkg

// [logic/clar_refill_chan.sv]
`timescale 1ns/100ps
`include "clar_cfg.svh"
module clar_refill_chan #(
    parameter int TICK_CYC = `CLAR_TICK_CYC
) (
    input  wire logic                     core_clk,
    input  wire logic                     rstn,
    input  wire logic                     sampleValid,
    input  wire clar_pkg::clar_level_type levelIn,
    input  wire clar_pkg::clar_level_type lowLimit,
    input  wire clar_pkg::clar_level_type highLimit,
    input  wire logic [15:0]              timeoutTicks,
    input  wire logic                     manualStart,
    input  wire logic                     manualStop,
    output logic                          fillOn,
    output logic                          fillStart,
    output logic                          fillEnd,
    output logic                          timedOut
);
    import clar_pkg::*;
    clar_fill_type  state_r;
    logic [31:0]    tickCnt_r;
    logic [15:0]    elapsed_r;
    logic           lowHit;
    logic           highHit;
    logic           tmoHit;
    logic           manPend_r;

    assign lowHit  = sampleValid && (lowLimit != 16'h0000) && (levelIn < lowLimit);
    assign highHit = sampleValid && (levelIn > highLimit);
    assign tmoHit  = (timeoutTicks != 16'h0000) && (elapsed_r >= timeoutTicks);
    assign fillOn  = (state_r == CLAR_FILL);

    // manual start waits in a pending latch
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            manPend_r <= 1'b0;
        end else if (state_r == CLAR_FILL || manualStop) begin
            manPend_r <= 1'b0;
        end else if (manualStart) begin
            manPend_r <= 1'b1;
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            state_r   <= CLAR_IDLE;
            fillStart <= 1'b0;
            fillEnd   <= 1'b0;
            timedOut  <= 1'b0;
        end else begin
            fillStart <= 1'b0;
            fillEnd   <= 1'b0;
            timedOut  <= 1'b0;
            case (state_r)
                CLAR_IDLE: begin
                    if ((lowHit || manPend_r) && lowLimit != 16'h0000) begin
                        state_r   <= CLAR_FILL;
                        fillStart <= 1'b1;
                    end
                end
                CLAR_FILL: begin
                    if (tmoHit) begin
                        state_r  <= CLAR_DONE;
                        fillEnd  <= 1'b1;
                        timedOut <= 1'b1;
                    end else if (highHit || manualStop || lowLimit == 16'h0000) begin
                        state_r <= CLAR_DONE;
                        fillEnd <= 1'b1;
                    end
                end
                CLAR_DONE: begin
                    state_r <= CLAR_IDLE;
                end
                default: begin
                    state_r <= CLAR_IDLE;
                end
            endcase
        end
    end

    // elapsed ticks since fill start
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            tickCnt_r <= 32'h0000_0000;
            elapsed_r <= 16'h0000;
        end else if (state_r != CLAR_FILL) begin
            tickCnt_r <= 32'h0000_0000;
            elapsed_r <= 16'h0000;
        end else if (tickCnt_r >= 32'(TICK_CYC - 1)) begin
            tickCnt_r <= 32'h0000_0000;
            if (elapsed_r != 16'hFFFF) begin
                elapsed_r <= elapsed_r + 16'h0001;
            end
        end else begin
            tickCnt_r <= tickCnt_r + 32'h0000_0001;
        end
    end
endmodule : clar_refill_chan
